// ---- rtl/pdc_pkg.sv ----
// pdc_pkg: shared constants and types for the power-down / self-test pin control block
// assumes a single 100 MHz clock domain and an axi4-lite register slave in the main module
package pdc_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] PDC_OFF_CTRL = 8'h00;
	localparam logic [7:0] PDC_OFF_FUNC = 8'h04;
	localparam logic [7:0] PDC_OFF_GP_OUT = 8'h08;
	localparam logic [7:0] PDC_OFF_GP_OE = 8'h0c;
	localparam logic [7:0] PDC_OFF_STATUS = 8'h10;
	localparam logic [7:0] PDC_OFF_AUDIO = 8'h14;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int PDC_CTRL_PASS_BIT = 0;
	localparam int PDC_FUNC_GP0_LSB = 0;
	localparam int PDC_FUNC_GP1_BIT = 2;
	localparam int PDC_FUNC_GP2_BIT = 3;
	localparam int PDC_FUNC_GP3_BIT = 4;
	localparam int PDC_ST_ENABLED_BIT = 0;
	localparam int PDC_ST_SELFTEST_BIT = 1;
	localparam int PDC_ST_CLKSEL_BIT = 2;
	localparam int PDC_ST_IRQ_BIT = 3;
	localparam int PDC_ST_GPIN_LSB = 4;
	localparam logic [3:0] PDC_GP_OUT_RST = 4'h0;
	localparam logic [3:0] PDC_GP_OE_RST = 4'hf;
	localparam logic [4:0] PDC_FUNC_RST = 5'h00;
	localparam logic [3:0] PDC_AUDIO_RST = 4'h0;
	localparam int PDC_SYNC_STAGES = 2;

	// gp0 function codes
	localparam logic [1:0] PDC_GP0_GPIO = 2'h0;
	localparam logic [1:0] PDC_GP0_AUDIO = 2'h1;
	localparam logic [1:0] PDC_GP0_PASS = 2'h2;

	// axi response codes
	localparam logic [1:0] PDC_RESP_OKAY = 2'h0;
	localparam logic [1:0] PDC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {PDC_SRC_PIXEL, PDC_SRC_INT33} pdc_clksrc_e;

	typedef enum {PDC_OFF, PDC_RESET, PDC_RUN} pdc_state_e;

	// decoded mode bundle handed to the rest of the chip
	typedef struct packed {
		logic enabled;
		logic selftest;
		pdc_clksrc_e clk_src;
		logic irq_in;
	} pdc_mode_s;

	// four general pins as two signals
	typedef struct packed {
		logic [3:0] o;
		logic [3:0] oe_n;
	} pdc_gpio_s;

endpackage

// ---- rtl/pdc_sync.sv ----
// pdc_sync: multi-bit two-stage synchroniser for asynchronous pin levels
// assumes each bit is an independent level; no bus coherency is implied
`timescale 1ns/1ns
module pdc_sync
	import pdc_pkg::*;
#(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	// first stage feeds only the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1 <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule // pdc_sync

// ---- rtl/pdc_pin_ctrl.sv ----
// pdc_pin_ctrl: control-pin decode, power-down sequencing and general pin muxing
// assumes pins arrive asynchronously; the pad ring resolves oe_n into tri-state levels
//
// What this block does
// - power-down input going high enables device and resets registers and state machines
// - power-down input low keeps device off with no normal operation
// - while off all single-ended outputs float and pll is shut down
// - undriven power-down input reads low, so the device stays off
// - self-test enable pin low disables, high enables self-test mode
// - in self-test, clock select 0 picks pixel clock, 1 internal 33 MHz
// - clock-select function of shared pin is honoured only during self-test
// - outside self-test the shared pin acts as interrupt input
// - after reset the four general pins are outputs driving low
// - registers may switch general pin 0 to serial audio out or pass flag
// - registers give pins 1-3 word clock and audio data lines c and d
`timescale 1ns/1ns
module pdc_pin_ctrl
	import pdc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic powerdown_n_input,
	input wire logic selftest_enable_pin,
	input wire logic selftest_clock_select,
	input wire logic [3:0] general_pin_in,
	output pdc_gpio_s general_pin,
	output pdc_mode_s mode,
	output logic pll_enable,
	output logic outputs_float,
	output logic core_reset_n,
	input wire logic serial_audio_out,
	input wire logic audio_word_clock_alt,
	input wire logic audio_data_line_c,
	input wire logic audio_data_line_d,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] ctl_sync;
	logic [3:0] gpin_sync;
	logic pd_n_s;
	logic st_en_s;
	logic st_clk_s;

	// an undriven pin is pulled low in the pad, so low also resets here
	pdc_sync #(.WIDTH(3), .RST_VAL(3'h0)) u_ctl_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({selftest_clock_select, selftest_enable_pin, powerdown_n_input}),
		.sync_out(ctl_sync)
	);
	pdc_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_gp_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(general_pin_in),
		.sync_out(gpin_sync)
	);
	assign pd_n_s = ctl_sync[0];
	assign st_en_s = ctl_sync[1];
	assign st_clk_s = ctl_sync[2];

	// ----------------------------------------------------------------
	// power sequencer
	// ----------------------------------------------------------------
	pdc_state_e state;
	pdc_state_e next_state;
	logic soft_rst;

	always_comb begin
		next_state = state;
		case (state)
			PDC_OFF: if (pd_n_s) next_state = PDC_RESET;
			PDC_RESET: next_state = pd_n_s ? PDC_RUN : PDC_OFF;
			PDC_RUN: if (!pd_n_s) next_state = PDC_OFF;
			default: next_state = PDC_OFF;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			state <= PDC_OFF;
		else
			state <= next_state;
	end

	// registers held at default except while running
	assign soft_rst = !aresetn || (state != PDC_RUN);
	assign core_reset_n = (state == PDC_RUN);
	assign pll_enable = (state != PDC_OFF);
	assign outputs_float = (state == PDC_OFF);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic pass_flag;
	logic [4:0] func_sel;
	logic [3:0] gp_out;
	logic [3:0] gp_oe;
	logic [3:0] audio_mirror;

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic wr_hit;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	function automatic logic is_rw_reg(input logic [ADDR_W-1:0] a);
		logic [7:0] b;
		b = 8'(a);
		is_rw_reg = (b == PDC_OFF_CTRL) || (b == PDC_OFF_FUNC) || (b == PDC_OFF_GP_OUT) ||
			(b == PDC_OFF_GP_OE);
	endfunction

	assign wr_hit = is_rw_reg(aw_addr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PDC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? PDC_RESP_OKAY : PDC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// writes only land while running; an off or resetting device keeps defaults
	always_ff @(posedge aclk) begin
		if (soft_rst) begin
			pass_flag <= 1'b0;
			func_sel <= PDC_FUNC_RST;
			gp_out <= PDC_GP_OUT_RST;
			gp_oe <= PDC_GP_OE_RST;
		end else if (do_write && w_strb[0]) begin
			if (8'(aw_addr) == PDC_OFF_CTRL)
				pass_flag <= w_data[PDC_CTRL_PASS_BIT];
			else if (8'(aw_addr) == PDC_OFF_FUNC)
				func_sel <= w_data[4:0];
			else if (8'(aw_addr) == PDC_OFF_GP_OUT)
				gp_out <= w_data[3:0];
			else if (8'(aw_addr) == PDC_OFF_GP_OE)
				gp_oe <= w_data[3:0];
		end
	end

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	logic run;
	logic st_active;

	assign run = (state == PDC_RUN);
	assign st_active = run && st_en_s;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode <= '0;
		end else begin
			mode.enabled <= run;
			mode.selftest <= st_active;
			// shared pin: clock select only in self-test, else interrupt
			mode.clk_src <= (st_active && st_clk_s) ? PDC_SRC_INT33 : PDC_SRC_PIXEL;
			mode.irq_in <= run && !st_en_s && st_clk_s;
		end
	end

	// ----------------------------------------------------------------
	// general pin mux
	// ----------------------------------------------------------------
	logic [3:0] next_o;
	logic [3:0] next_oe;

	always_comb begin
		next_o = gp_out;
		next_oe = gp_oe;
		case (func_sel[1:0])
			PDC_GP0_AUDIO: begin
				next_o[0] = serial_audio_out;
				next_oe[0] = 1'b1;
			end
			PDC_GP0_PASS: begin
				next_o[0] = pass_flag;
				next_oe[0] = 1'b1;
			end
			default: begin
				next_o[0] = gp_out[0];
				next_oe[0] = gp_oe[0];
			end
		endcase
		if (func_sel[PDC_FUNC_GP1_BIT]) begin
			next_o[1] = audio_word_clock_alt;
			next_oe[1] = 1'b1;
		end
		if (func_sel[PDC_FUNC_GP2_BIT]) begin
			next_o[2] = audio_data_line_c;
			next_oe[2] = 1'b1;
		end
		if (func_sel[PDC_FUNC_GP3_BIT]) begin
			next_o[3] = audio_data_line_d;
			next_oe[3] = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			general_pin.o <= 4'h0;
			general_pin.oe_n <= 4'hf;
		end else if (state == PDC_OFF) begin
			general_pin.o <= 4'h0;
			general_pin.oe_n <= 4'hf;
		end else begin
			general_pin.o <= run ? next_o : PDC_GP_OUT_RST;
			general_pin.oe_n <= run ? ~next_oe : ~PDC_GP_OE_RST;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			audio_mirror <= PDC_AUDIO_RST;
		else
			audio_mirror <= {audio_data_line_d, audio_data_line_c, audio_word_clock_alt, serial_audio_out};
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	logic [31:0] rd_word;
	logic rd_ok;

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		if (8'(s_axi_araddr) == PDC_OFF_CTRL)
			rd_word[PDC_CTRL_PASS_BIT] = pass_flag;
		else if (8'(s_axi_araddr) == PDC_OFF_FUNC)
			rd_word[4:0] = func_sel;
		else if (8'(s_axi_araddr) == PDC_OFF_GP_OUT)
			rd_word[3:0] = gp_out;
		else if (8'(s_axi_araddr) == PDC_OFF_GP_OE)
			rd_word[3:0] = gp_oe;
		else if (8'(s_axi_araddr) == PDC_OFF_STATUS)
			rd_word[7:0] = {gpin_sync, mode.irq_in, mode.clk_src == PDC_SRC_INT33, mode.selftest, mode.enabled};
		else if (8'(s_axi_araddr) == PDC_OFF_AUDIO)
			rd_word[3:0] = audio_mirror;
		else
			rd_ok = 1'b0;
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= PDC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? PDC_RESP_OKAY : PDC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_off_floats_pins: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == PDC_OFF) |=> (general_pin.oe_n == 4'hf)) else $error("pins driven while off");
	a_off_pll_down: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == PDC_OFF) |-> (!pll_enable && outputs_float)) else $error("pll on while off");
	a_low_stays_off: assert property (@(posedge aclk) disable iff (!aresetn)
		(!pd_n_s && state != PDC_RUN) |=> (state != PDC_RUN)) else $error("left off while input low");
	a_wake_resets: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == PDC_OFF && pd_n_s) |=> (state == PDC_RESET) ##1 (func_sel == PDC_FUNC_RST))
		else $error("no reset on wake");
	a_pd_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(pd_n_s) |-> $past(powerdown_n_input, 2)) else $error("power-down sync depth wrong");
	a_clk_sel_gated: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode.clk_src == PDC_SRC_INT33) |-> $past(st_active && st_clk_s)) else $error("clock select outside test");
	a_irq_only_normal: assert property (@(posedge aclk) disable iff (!aresetn)
		mode.irq_in |-> !mode.selftest) else $error("interrupt during self-test");
	a_st_follows_pin: assert property (@(posedge aclk) disable iff (!aresetn)
		(run && st_en_s) ##1 run |-> mode.selftest) else $error("self-test not entered");
	a_gp_default_low: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == PDC_RESET) |=> (general_pin.o == 4'h0 && general_pin.oe_n == 4'h0)) else $error("pins not low");
	a_gp0_pass: assert property (@(posedge aclk) disable iff (!aresetn)
		(run && func_sel[1:0] == PDC_GP0_PASS) ##1 run |-> (general_pin.o[0] == $past(pass_flag)))
		else $error("pass not on pin 0");
	a_gp1_wclk: assert property (@(posedge aclk) disable iff (!aresetn)
		(run && func_sel[PDC_FUNC_GP1_BIT]) ##1 run |-> (general_pin.o[1] == $past(audio_word_clock_alt)))
		else $error("word clock missing");

endmodule // pdc_pin_ctrl

// ---- verification/pdc_host_model.sv ----
// pdc_host_model: host processor side of the control and general pins
// assumes pad pulldowns; device drive wins on a general pin when oe_n is low
`timescale 1ns/1ns
module pdc_host_model
	import pdc_pkg::*;
(
	input wire logic pd_drv,
	input wire logic pd_lvl,
	input wire logic st_lvl,
	input wire logic cs_lvl,
	input wire logic [3:0] gp_lvl,
	input wire pdc_gpio_s general_pin,
	output logic powerdown_n_input,
	output logic selftest_enable_pin,
	output logic selftest_clock_select,
	output logic [3:0] general_pin_in
);
	// ----------------------------------------------------------------
	// pin levels
	// ----------------------------------------------------------------
	// released pin falls to the weak pulldown, so the device stays off
	assign powerdown_n_input = pd_drv & pd_lvl;
	assign selftest_enable_pin = st_lvl;
	assign selftest_clock_select = cs_lvl;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			general_pin_in[i] = general_pin.oe_n[i] ? gp_lvl[i] : general_pin.o[i];
		end
	end
endmodule // pdc_host_model

// ---- verification/testbench.sv ----
// testbench: self-checking bench for pdc_pin_ctrl
// assumes the host model on the pins and an axi4-lite master here
`timescale 1ns/1ns
module testbench
	import pdc_pkg::*;
;
	logic aclk = 0;
	logic aresetn = 0;
	logic pd_drv = 0, pd_lvl = 0, st_lvl = 0, cs_lvl = 0;
	logic [3:0] gp_lvl = 4'h0, aud = 4'h0, gin;
	logic pdn, sten, csel, awready, wready, bvalid, arready, rvalid, pll, flt, crn;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [1:0] bresp, rresp;
	pdc_gpio_s gpo;
	pdc_mode_s mode;
	int fail_count = 0;
	int cmp_count = 0;
	// {selftest, select, pins, clk source, status byte}
	logic [15:0] rows [4] = '{16'h0c31, 16'h5459, 16'ha8a3, 16'hf1c7};

	always #5 aclk = ~aclk;

	pdc_host_model pdc_host_model_i (.pd_drv(pd_drv), .pd_lvl(pd_lvl), .st_lvl(st_lvl), .cs_lvl(cs_lvl),
		.gp_lvl(gp_lvl), .general_pin(gpo), .powerdown_n_input(pdn), .selftest_enable_pin(sten),
		.selftest_clock_select(csel), .general_pin_in(gin));

	pdc_pin_ctrl pdc_pin_ctrl_i (.aclk(aclk), .aresetn(aresetn), .powerdown_n_input(pdn),
		.selftest_enable_pin(sten), .selftest_clock_select(csel), .general_pin_in(gin), .general_pin(gpo),
		.mode(mode), .pll_enable(pll), .outputs_float(flt), .core_reset_n(crn), .serial_audio_out(aud[0]),
		.audio_word_clock_alt(aud[1]), .audio_data_line_c(aud[2]), .audio_data_line_d(aud[3]),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic end_sim;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (n < 50) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) begin
				bready <= 0;
				cmp(32'(bresp), 32'(er));
				n = 99;
			end
		end
		if (n == 50) cmp(32'h1, 32'h0);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		d = 32'hx;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (n < 50) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) begin
				rready <= 0;
				d = rdata;
				cmp(32'(rresp), 32'(er));
				n = 99;
			end
		end
		if (n == 50) cmp(32'h1, 32'h0);
	endtask

	// {pll, float, core reset_n, oe_n, o}
	// looked at mid-cycle where outputs have settled; returns on a rising edge
	task automatic pins(input logic [10:0] e);
		@(negedge aclk);
		cmp(32'({pll, flt, crn, gpo.oe_n, gpo.o}), 32'(e));
		@(posedge aclk);
	endtask

	// covers the two-flop sync plus the reset and run states
	task automatic wt;
		repeat (6) @(posedge aclk);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		pins(11'h2f0);
		pd_drv <= 1;
		pd_lvl <= 1;
		wt;
		pins(11'h500);
		axw(PDC_OFF_GP_OE, 32'h0, PDC_RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			st_lvl <= rows[i][15];
			cs_lvl <= rows[i][14];
			gp_lvl <= rows[i][13:10];
			wt;
			axr(PDC_OFF_STATUS, rd, PDC_RESP_OKAY);
			cmp(rd, 32'(rows[i][7:0]));
			cmp(32'(mode), 32'({1'b1, rows[i][15], rows[i][9:8], rows[i][3]}));
		end
		axw(PDC_OFF_GP_OE, 32'hf, PDC_RESP_OKAY);
		aud <= 4'hb;
		axw(PDC_OFF_FUNC, 32'h1d, PDC_RESP_OKAY);
		pins(11'h50b);
		axr(PDC_OFF_AUDIO, rd, PDC_RESP_OKAY);
		cmp(rd, 32'hb);
		axw(PDC_OFF_CTRL, 32'h1, PDC_RESP_OKAY);
		axw(PDC_OFF_GP_OUT, 32'h4, PDC_RESP_OKAY);
		axw(PDC_OFF_FUNC, 32'h2, PDC_RESP_OKAY);
		pins(11'h505);
		axr(PDC_OFF_FUNC, rd, PDC_RESP_OKAY);
		cmp(rd, 32'h2);
		axw(8'h18, 32'h1, PDC_RESP_SLVERR);
		axr(8'h18, rd, PDC_RESP_SLVERR);
		cmp(rd, 32'h0);
		// release the pin mid-run: pulldown must power the device down
		pd_drv <= 0;
		wt;
		pins(11'h2f0);
		axw(PDC_OFF_GP_OUT, 32'hf, PDC_RESP_OKAY);
		// a write while off must not land, and no mode may show
		axr(PDC_OFF_GP_OUT, rd, PDC_RESP_OKAY);
		cmp(rd, 32'h0);
		axr(PDC_OFF_STATUS, rd, PDC_RESP_OKAY);
		cmp(rd, 32'hc0);
		pd_drv <= 1;
		wt;
		pins(11'h500);
		axr(PDC_OFF_FUNC, rd, PDC_RESP_OKAY);
		cmp(rd, 32'h0);
		axr(PDC_OFF_GP_OUT, rd, PDC_RESP_OKAY);
		cmp(rd, 32'h0);
		end_sim;
	end

	initial begin
		repeat (5000) @(posedge aclk);
		fail_count++;
		end_sim;
	end
endmodule // testbench
